// File: rps_pkg.sv
`default_nettype none
package rps_pkg;
  // widths
  localparam int unsigned PC_W = 13;
  localparam int unsigned IW = 14;
  localparam int unsigned DW = 8;
  localparam int unsigned SP_W = 3;
  // program space vectors and wrap masks
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  localparam logic [12:0] MASK_SMALL = 13'h01FF;
  localparam logic [12:0] MASK_LARGE = 13'h07FF;
  // special instruction words
  localparam logic [13:0] WORD_NOP = 14'h0000;
  localparam logic [13:0] WORD_RETURN = 14'h0008;
  localparam logic [13:0] WORD_RETFIE = 14'h0009;
  // special register addresses within a bank
  localparam logic [6:0] A_INDF = 7'h00;
  localparam logic [6:0] A_PCL = 7'h02;
  localparam logic [6:0] A_STATUS = 7'h03;
  localparam logic [6:0] A_FSR = 7'h04;
  localparam logic [6:0] A_PCLATH = 7'h0A;
  // status bit positions and reset value
  localparam int unsigned B_C = 0;
  localparam int unsigned B_DC = 1;
  localparam int unsigned B_Z = 2;
  localparam int unsigned B_RP0 = 5;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // apb register offsets and control bits
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PC = 12'h004;
  localparam logic [11:0] OFF_CORE = 12'h008;
  localparam int unsigned C_RC = 0;
  localparam int unsigned C_LARGE = 1;
  localparam int unsigned C_IRQ = 2;
  // phases of one instruction cycle, gray order
  typedef enum logic [1:0] {
    PH_ONE = 2'h0, PH_TWO = 2'h1, PH_THREE = 2'h3, PH_FOUR = 2'h2
  } rps_phase_t;
  // arithmetic unit operations
  typedef enum logic [3:0] {
    ALU_PASS_A, ALU_PASS_B, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM,
    ALU_INC, ALU_DEC, ALU_RRF, ALU_RLF, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
  } rps_alu_op_t;
endpackage : rps_pkg
`default_nettype wire

// File: rps_alu_if.sv
`default_nettype none
interface rps_alu_if;
  rps_pkg::rps_alu_op_t op; // operation
  logic [7:0] a; // accumulator operand
  logic [7:0] b; // file or literal operand
  logic cin; // carry in for rotates
  logic [2:0] bsel; // bit index for bit ops
  logic [7:0] res; // result
  logic c; // carry / not borrow
  logic dc; // nibble carry / not nibble borrow
  logic z; // result is zero
  modport core (output op, a, b, cin, bsel, input res, c, dc, z);
  modport alu (input op, a, b, cin, bsel, output res, c, dc, z);
endinterface : rps_alu_if
`default_nettype wire

// File: rps_alu.sv
`default_nettype none
module rps_alu (
  // operands in, result and flags out
  rps_alu_if.alu bus
);
  // operation classes feeding the adder
  wire logic is_sub = bus.op == rps_pkg::ALU_SUB;
  wire logic is_inc = bus.op == rps_pkg::ALU_INC;
  wire logic is_dec = bus.op == rps_pkg::ALU_DEC;
  // subtract as b + ~a + 1, so carry is inverted borrow
  wire logic [7:0] addend = is_sub ? ~bus.a : is_inc ? 8'h01 : is_dec ? 8'hFF : bus.a;
  wire logic [8:0] sum = {1'b0, bus.b} + {1'b0, addend} + {8'h00, is_sub};
  wire logic [4:0] nib = {1'b0, bus.b[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
  wire logic [7:0] bit_mask = 8'h01 << bus.bsel;

  // result and carry selection
  always_comb begin
    bus.res = bus.b;
    bus.c = sum[8];
    unique case (bus.op)
      rps_pkg::ALU_PASS_A: bus.res = bus.a;
      rps_pkg::ALU_PASS_B: bus.res = bus.b;
      rps_pkg::ALU_ADD: bus.res = sum[7:0];
      rps_pkg::ALU_SUB: bus.res = sum[7:0];
      rps_pkg::ALU_INC: bus.res = sum[7:0];
      rps_pkg::ALU_DEC: bus.res = sum[7:0];
      rps_pkg::ALU_AND: bus.res = bus.a & bus.b;
      rps_pkg::ALU_IOR: bus.res = bus.a | bus.b;
      rps_pkg::ALU_XOR: bus.res = bus.a ^ bus.b;
      rps_pkg::ALU_COM: bus.res = ~bus.b;
      rps_pkg::ALU_RRF: begin // rotate right through carry
        bus.res = {bus.cin, bus.b[7:1]};
        bus.c = bus.b[0];
      end
      rps_pkg::ALU_RLF: begin // rotate left through carry
        bus.res = {bus.b[6:0], bus.cin};
        bus.c = bus.b[7];
      end
      rps_pkg::ALU_SWAP: bus.res = {bus.b[3:0], bus.b[7:4]};
      rps_pkg::ALU_CLR: bus.res = 8'h00;
      rps_pkg::ALU_BCLR: bus.res = bus.b & ~bit_mask;
      rps_pkg::ALU_BSET: bus.res = bus.b | bit_mask;
    endcase
  end

  // nibble carry and zero
  assign bus.dc = nib[4];
  assign bus.z = bus.res == 8'h00;
endmodule : rps_alu
`default_nettype wire

// File: rps_core.sv
`default_nettype none
module rps_core (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // master clear pin, active low, asynchronous
  input wire logic MASTER_CLEAR_N_I,
  // crystal-out pin carrying the cycle clock
  output logic CYCLE_CLK_O,
  // program memory
  output logic [12:0] PMEM_ADDR_O,
  input wire logic [13:0] PMEM_DATA_I,
  // data register file
  output logic [7:0] DMEM_ADDR_O,
  output logic DMEM_RE_O,
  input wire logic [7:0] DMEM_RDATA_I,
  output logic DMEM_WE_O,
  output logic [7:0] DMEM_WDATA_O,
  // apb slave
  input wire logic [11:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  // reset synchroniser
  logic [1:0] rst_sync_reg;
  // master clear synchroniser and core reset
  logic [1:0] master_clear_pin_sync_reg;
  logic core_rst_n_reg;
  // apb side state
  logic rc_reg; // rc oscillator mode
  logic large_reg; // 2k-word program memory variant
  logic irq_pend_reg; // interrupt request pending
  logic [31:0] prdata_reg;
  // sequencing state
  rps_pkg::rps_phase_t phase_reg;
  rps_pkg::rps_phase_t phase_next;
  logic cyc_clk_reg;
  logic [12:0] pc_reg; // program counter
  logic [12:0] fetch_addr_reg; // address being fetched
  logic [13:0] fetch_reg; // prefetched word
  logic [13:0] ir_reg; // instruction latch
  logic flush_reg; // discard prefetched word
  // execution state
  logic [7:0] dmem_addr_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic c_reg;
  logic dc_reg;
  logic z_reg;
  logic [7:0] w_reg; // working accumulator
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] fsr_reg;
  logic [4:0] pclath_reg;
  // return stack
  logic [12:0] stack_mem [8];
  logic [2:0] sp_reg;
  // decoded controls
  rps_pkg::rps_alu_op_t dec_op;
  logic use_lit, rd_f, wr_f, wr_w, aff_z, aff_c, aff_dc;
  logic do_goto, do_call, do_ret, do_retlw, skip_z, skip_clr, skip_set;

  // release the asynchronous reset through two flops
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  wire logic rst_n = rst_sync_reg[1];

  // master clear pin sampled by two flops, then held as core reset
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_sync_reg <= 2'h0;
      core_rst_n_reg <= 1'b0;
    end else begin
      master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[0], MASTER_CLEAR_N_I};
      core_rst_n_reg <= master_clear_pin_sync_reg[1];
    end
  end

  // apb decode
  wire logic apb_setup = PSEL_I && !PENABLE_I;
  wire logic apb_access = PSEL_I && PENABLE_I;
  wire logic hit_ctrl = PADDR_I == rps_pkg::OFF_CTRL;
  wire logic hit_pc = PADDR_I == rps_pkg::OFF_PC;
  wire logic hit_core = PADDR_I == rps_pkg::OFF_CORE;
  wire logic apb_mapped = hit_ctrl || hit_pc || hit_core;
  wire logic ctrl_wr = apb_access && PWRITE_I && hit_ctrl;
  wire logic [31:0] apb_rd_mux =
    hit_ctrl ? {29'h0000_0000, irq_pend_reg, large_reg, rc_reg} :
    hit_pc ? {3'h0, pc_reg, 3'h0, fetch_addr_reg} :
    hit_core ? {2'h0, ir_reg, status_reg, w_reg} : 32'h0000_0000;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_access && !apb_mapped;
  assign PRDATA_O = prdata_reg;

  // sequencing strobes
  wire logic ph1 = phase_reg == rps_pkg::PH_ONE;
  wire logic ph2 = phase_reg == rps_pkg::PH_TWO;
  wire logic ph3 = phase_reg == rps_pkg::PH_THREE;
  wire logic ph4 = phase_reg == rps_pkg::PH_FOUR;

  // data address of the word entering the latch, bank or indirect
  wire logic [13:0] ir_in = flush_reg ? rps_pkg::WORD_NOP : fetch_reg;
  wire logic [7:0] daddr_in = (ir_in[6:0] == rps_pkg::A_INDF) ? fsr_reg :
                              {status_reg[rps_pkg::B_RP0], ir_in[6:0]};
  // special registers decoded in both banks
  wire logic [6:0] dlow = dmem_addr_reg[6:0];
  wire logic hit_indf = dlow == rps_pkg::A_INDF;
  wire logic hit_pcl = dlow == rps_pkg::A_PCL;
  wire logic hit_status = dlow == rps_pkg::A_STATUS;
  wire logic hit_fsr = dlow == rps_pkg::A_FSR;
  wire logic hit_pclath = dlow == rps_pkg::A_PCLATH;
  wire logic sfr_hit = hit_indf || hit_pcl || hit_status || hit_fsr || hit_pclath;
  wire logic [7:0] sfr_rd = hit_pcl ? fetch_addr_reg[7:0] : hit_status ? status_reg :
                            hit_fsr ? fsr_reg : hit_pclath ? {3'h0, pclath_reg} : 8'h00;

  // branch and redirect decisions
  wire logic bit_val = operand_reg[ir_reg[9:7]];
  wire logic skip_taken = (skip_z && z_reg) || (skip_clr && !bit_val) || (skip_set && bit_val);
  wire logic wr_pcl = wr_f && hit_pcl;
  wire logic take_branch = do_goto || do_call || do_ret || do_retlw || wr_pcl || skip_taken;
  wire logic irq_take = ph4 && irq_pend_reg && !take_branch;
  wire logic redirect = take_branch || irq_take;
  wire logic [12:0] stack_top = stack_mem[sp_reg - 3'h1];
  wire logic [12:0] jump_target = {pclath_reg[4:3], ir_reg[10:0]};
  wire logic [12:0] pc_target =
    irq_take ? rps_pkg::INT_VEC :
    (do_goto || do_call) ? jump_target :
    (do_ret || do_retlw) ? stack_top :
    wr_pcl ? {pclath_reg, result_reg} : pc_reg;
  wire logic [12:0] pmem_mask = large_reg ? rps_pkg::MASK_LARGE : rps_pkg::MASK_SMALL;
  wire logic flags_aff = aff_z || aff_c || aff_dc;

  // memory ports
  assign PMEM_ADDR_O = fetch_addr_reg;
  assign DMEM_ADDR_O = dmem_addr_reg;
  assign DMEM_RE_O = ph2 && rd_f && !sfr_hit;
  assign DMEM_WE_O = ph4 && wr_f && !sfr_hit;
  assign DMEM_WDATA_O = result_reg;
  assign CYCLE_CLK_O = cyc_clk_reg;

  // arithmetic unit hookup
  rps_alu_if alu_bus ();
  assign alu_bus.op = dec_op;
  assign alu_bus.a = w_reg;
  assign alu_bus.b = use_lit ? ir_reg[7:0] : operand_reg;
  assign alu_bus.cin = status_reg[rps_pkg::B_C];
  assign alu_bus.bsel = ir_reg[9:7];
  rps_alu u_alu (
    .bus(alu_bus)
  );

  // apb control register, interrupt request set wins over accept
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rc_reg <= 1'b0;
      large_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (ctrl_wr) begin
        rc_reg <= PWDATA_I[rps_pkg::C_RC];
        large_reg <= PWDATA_I[rps_pkg::C_LARGE];
      end
      if (ctrl_wr && PWDATA_I[rps_pkg::C_IRQ]) begin
        irq_pend_reg <= 1'b1;
      end else if (irq_take) begin
        irq_pend_reg <= 1'b0;
      end
      if (apb_setup) begin
        prdata_reg <= apb_rd_mux;
      end
    end
  end

  // phase order one, two, three, four
  always_comb begin
    unique case (phase_reg)
      rps_pkg::PH_ONE: phase_next = rps_pkg::PH_TWO;
      rps_pkg::PH_TWO: phase_next = rps_pkg::PH_THREE;
      rps_pkg::PH_THREE: phase_next = rps_pkg::PH_FOUR;
      rps_pkg::PH_FOUR: phase_next = rps_pkg::PH_ONE;
    endcase
  end

  // divide by four and cycle clock, high in phases one and two
  always_ff @(posedge CLK_I or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      phase_reg <= rps_pkg::PH_ONE;
      cyc_clk_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      // only start a pulse at phase one, so enabling mid-cycle gives no runt
      cyc_clk_reg <= rc_reg && (phase_next == rps_pkg::PH_ONE ||
                                (phase_next == rps_pkg::PH_TWO && cyc_clk_reg));
    end
  end

  // fetch stage: pc, prefetch word, instruction latch
  always_ff @(posedge CLK_I or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      pc_reg <= rps_pkg::RESET_VEC;
      fetch_addr_reg <= rps_pkg::RESET_VEC;
      fetch_reg <= rps_pkg::WORD_NOP;
      ir_reg <= rps_pkg::WORD_NOP;
      flush_reg <= 1'b1;
      dmem_addr_reg <= 8'h00;
    end else begin
      if (ph1) begin
        ir_reg <= ir_in;
        dmem_addr_reg <= daddr_in;
        fetch_addr_reg <= pc_reg & pmem_mask;
        pc_reg <= pc_reg + 13'h0001;
        flush_reg <= 1'b0;
      end
      if (ph4) begin
        fetch_reg <= PMEM_DATA_I;
        if (redirect) begin
          pc_reg <= pc_target;
          flush_reg <= 1'b1;
        end
      end
    end
  end

  // operand read in phase two, alu result held in phase three
  always_ff @(posedge CLK_I or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
      c_reg <= 1'b0;
      dc_reg <= 1'b0;
      z_reg <= 1'b0;
    end else begin
      if (ph2) begin
        operand_reg <= sfr_hit ? sfr_rd : DMEM_RDATA_I;
      end
      if (ph3) begin
        result_reg <= alu_bus.res;
        c_reg <= alu_bus.c;
        dc_reg <= alu_bus.dc;
        z_reg <= alu_bus.z;
      end
    end
  end

  // status next value: flag ops mask writes, timeout/powerdown read only
  always_comb begin
    status_next = status_reg;
    if (wr_f && hit_status) begin
      status_next = {result_reg[7:5], status_reg[4:3],
                     flags_aff ? status_reg[2:0] : result_reg[2:0]};
    end
    if (aff_z) begin
      status_next[rps_pkg::B_Z] = z_reg;
    end
    if (aff_c) begin
      status_next[rps_pkg::B_C] = c_reg;
    end
    if (aff_dc) begin
      status_next[rps_pkg::B_DC] = dc_reg;
    end
  end

  // destination write in phase four
  always_ff @(posedge CLK_I or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      w_reg <= 8'h00;
      status_reg <= rps_pkg::STATUS_RST;
      fsr_reg <= 8'h00;
      pclath_reg <= 5'h00;
    end else if (ph4) begin
      if (wr_w) begin
        w_reg <= result_reg;
      end
      status_reg <= status_next;
      if (wr_f && hit_fsr) begin
        fsr_reg <= result_reg;
      end
      if (wr_f && hit_pclath) begin
        pclath_reg <= result_reg[4:0];
      end
    end
  end

  // return stack pointer, wraps after eight levels
  always_ff @(posedge CLK_I or negedge core_rst_n_reg) begin
    if (!core_rst_n_reg) begin
      sp_reg <= 3'h0;
    end else if (ph4 && (do_call || irq_take)) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (ph4 && (do_ret || do_retlw)) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  // stack storage, return address is the discarded fetch
  always_ff @(posedge CLK_I) begin
    if (ph4 && (do_call || irq_take)) begin
      stack_mem[sp_reg] <= fetch_addr_reg;
    end
  end

  // instruction decode
  always_comb begin
    dec_op = rps_pkg::ALU_PASS_B;
    {use_lit, rd_f, wr_f, wr_w, aff_z, aff_c, aff_dc} = 7'h00;
    {do_goto, do_call, do_ret, do_retlw, skip_z, skip_clr, skip_set} = 7'h00;
    unique case (ir_reg[13:12])
      2'h0: begin // byte ops on a file register
        rd_f = ir_reg[11:9] != 3'h0;
        wr_f = ir_reg[7];
        wr_w = !ir_reg[7];
        aff_z = 1'b1;
        unique case (ir_reg[11:8])
          4'h0: begin // store accumulator, or control words
            dec_op = rps_pkg::ALU_PASS_A;
            wr_w = 1'b0;
            aff_z = 1'b0;
            do_ret = ir_reg == rps_pkg::WORD_RETURN || ir_reg == rps_pkg::WORD_RETFIE;
          end
          4'h1: dec_op = rps_pkg::ALU_CLR;
          4'h2: begin
            dec_op = rps_pkg::ALU_SUB;
            {aff_c, aff_dc} = 2'h3;
          end
          4'h3: dec_op = rps_pkg::ALU_DEC;
          4'h4: dec_op = rps_pkg::ALU_IOR;
          4'h5: dec_op = rps_pkg::ALU_AND;
          4'h6: dec_op = rps_pkg::ALU_XOR;
          4'h7: begin
            dec_op = rps_pkg::ALU_ADD;
            {aff_c, aff_dc} = 2'h3;
          end
          4'h8: dec_op = rps_pkg::ALU_PASS_B;
          4'h9: dec_op = rps_pkg::ALU_COM;
          4'hA: dec_op = rps_pkg::ALU_INC;
          4'hB: begin // decrement, skip if zero
            dec_op = rps_pkg::ALU_DEC;
            {aff_z, skip_z} = 2'h1;
          end
          4'hC: begin
            dec_op = rps_pkg::ALU_RRF;
            {aff_z, aff_c} = 2'h1;
          end
          4'hD: begin
            dec_op = rps_pkg::ALU_RLF;
            {aff_z, aff_c} = 2'h1;
          end
          4'hE: begin
            dec_op = rps_pkg::ALU_SWAP;
            aff_z = 1'b0;
          end
          4'hF: begin // increment, skip if zero
            dec_op = rps_pkg::ALU_INC;
            {aff_z, skip_z} = 2'h1;
          end
        endcase
      end
      2'h1: begin // bit clear, set and tests
        rd_f = 1'b1;
        unique case (ir_reg[11:10])
          2'h0: begin // bit clear
            dec_op = rps_pkg::ALU_BCLR;
            wr_f = 1'b1;
          end
          2'h1: begin // bit set
            dec_op = rps_pkg::ALU_BSET;
            wr_f = 1'b1;
          end
          2'h2: skip_clr = 1'b1;
          2'h3: skip_set = 1'b1;
        endcase
      end
      2'h2: begin // goto or call
        do_goto = ir_reg[11];
        do_call = !ir_reg[11];
      end
      2'h3: begin // literal ops into the accumulator
        use_lit = 1'b1;
        wr_w = 1'b1;
        unique casez (ir_reg[11:8])
          4'b00??: dec_op = rps_pkg::ALU_PASS_B;
          4'b01??: do_retlw = 1'b1;
          4'b1000: begin
            dec_op = rps_pkg::ALU_IOR;
            aff_z = 1'b1;
          end
          4'b1001: begin
            dec_op = rps_pkg::ALU_AND;
            aff_z = 1'b1;
          end
          4'b1010: begin
            dec_op = rps_pkg::ALU_XOR;
            aff_z = 1'b1;
          end
          4'b1011: wr_w = 1'b0;
          4'b110?: begin
            dec_op = rps_pkg::ALU_SUB;
            {aff_z, aff_c, aff_dc} = 3'h7;
          end
          4'b111?: begin
            dec_op = rps_pkg::ALU_ADD;
            {aff_z, aff_c, aff_dc} = 3'h7;
          end
        endcase
      end
    endcase
  end
endmodule : rps_core
`default_nettype wire

// File: rps_core_assertions.sv
`default_nettype none
module rps_core_chk (
  // clock and resets
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic MASTER_CLEAR_N_I,
  // watched outputs
  input wire logic CYCLE_CLK_O,
  input wire logic [12:0] PMEM_ADDR_O,
  input wire logic DMEM_RE_O,
  input wire logic DMEM_WE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] last_q; // fetch address one edge back
  logic [2:0] age_q; // edges since the fetch address moved
  logic [3:0] mc_q; // edges with master clear released
  wire chg = PMEM_ADDR_O != last_q; // seen during phase two
  wire run_ok = mc_q == 4'hF; // pipeline settled after a clear
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // phase tracker driven by fetch address movement
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      last_q <= 13'h0000;
      age_q <= 3'h7;
      mc_q <= 4'h0;
    end else begin
      last_q <= PMEM_ADDR_O;
      age_q <= chg ? 3'h1 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
      mc_q <= !MASTER_CLEAR_N_I ? 4'h0 : (run_ok ? mc_q : mc_q + 4'h1);
    end
  end
  // three quiet phases between fetch steps
  sequence s_quiet;
    !chg [*3];
  endsequence
  // cycle clock two high then two low
  sequence s_cyc;
    CYCLE_CLK_O ##1 !CYCLE_CLK_O [*2] ##1 CYCLE_CLK_O;
  endsequence
  AST_FETCH_EVERY_FOUR: assert property (disable iff (!NRST_I || !run_ok)
    chg |=> s_quiet ##1 chg) else $error("fetch not stepping every four clocks");
  AST_RE_PHASE_TWO: assert property (disable iff (!NRST_I || !run_ok)
    DMEM_RE_O |-> chg) else $error("data read outside phase two");
  AST_WE_PHASE_FOUR: assert property (disable iff (!NRST_I || !run_ok)
    DMEM_WE_O |-> age_q == 3'h2) else $error("data write outside phase four");
  AST_RE_ONCE: assert property (DMEM_RE_O |=> !DMEM_RE_O [*3])
    else $error("second data read in one cycle");
  AST_WE_ONCE: assert property (DMEM_WE_O |=> !DMEM_WE_O [*3])
    else $error("second data write in one cycle");
  AST_CYC_PERIOD: assert property (disable iff (!NRST_I || !run_ok)
    $rose(CYCLE_CLK_O) |=> s_cyc) else $error("cycle clock not quarter rate");
  AST_CYC_PHASE: assert property (disable iff (!NRST_I || !run_ok)
    $rose(CYCLE_CLK_O) |-> age_q == 3'h3) else $error("cycle clock not aligned to phase one");
  AST_MASTER_CLEAR_PIN_RESET: assert property ($fell(MASTER_CLEAR_N_I) |->
    ##[1:6] PMEM_ADDR_O == 13'h0000) else $error("master clear did not restart at zero");
  AST_FETCH_WRAP: assert property (PMEM_ADDR_O[12:11] == 2'b00)
    else $error("fetch outside implemented space");
endmodule : rps_core_chk
bind rps_core rps_core_chk u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .MASTER_CLEAR_N_I(MASTER_CLEAR_N_I), .CYCLE_CLK_O(CYCLE_CLK_O),
  .PMEM_ADDR_O(PMEM_ADDR_O), .DMEM_RE_O(DMEM_RE_O), .DMEM_WE_O(DMEM_WE_O));
`default_nettype wire

// File: rps_mem_model.sv
`default_nettype none
module rps_mem_model (
  // clock
  input wire logic clk_i,
  // program side
  input wire logic [12:0] pm_addr_i,
  output logic [13:0] pm_data_o,
  // data side
  input wire logic [7:0] dm_addr_i,
  input wire logic dm_re_i,
  output logic [7:0] dm_rdata_o,
  input wire logic dm_we_i,
  input wire logic [7:0] dm_wdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] rom [2048]; // program words, loaded by the bench
  logic [7:0] ram [256]; // data file
  logic [7:0] last_rd = 8'h00; // last byte handed out
  // word follows the address one clock late, well inside the wait
  always @(posedge clk_i) pm_data_o <= rom[pm_addr_i[10:0]];
  // read data only while strobed, otherwise the inverse of the last
  assign dm_rdata_o = dm_re_i ? ram[dm_addr_i] : ~last_rd;
  // capture read byte and perform writes at the edge
  always @(posedge clk_i) begin
    if (dm_re_i) last_rd <= ram[dm_addr_i];
    if (dm_we_i) ram[dm_addr_i] <= dm_wdata_i;
  end
endmodule : rps_mem_model
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, master_clear_pin_n = 1'b0; // clock and resets
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, cyc_clk, dm_re, dm_we;
  logic [12:0] pm_addr, last_a = 13'h1FFF;
  logic [13:0] pm_data;
  logic [7:0] dm_addr, dm_rdata, dm_wdata;
  logic [12:0] fq [$]; // fetch address log
  logic [15:0] wq [$]; // data write log, address then byte
  int miscompares = 0, checks_done = 0;
  localparam logic [15:0] wexp [5] = '{16'h205A, 16'h221F, 16'h23FF, 16'h2418, 16'hA03C};
  always #2.5 clk = ~clk;
  rps_core dut (.CLK_I(clk), .NRST_I(rst_n), .MASTER_CLEAR_N_I(master_clear_pin_n), .CYCLE_CLK_O(cyc_clk),
    .PMEM_ADDR_O(pm_addr), .PMEM_DATA_I(pm_data), .DMEM_ADDR_O(dm_addr), .DMEM_RE_O(dm_re),
    .DMEM_RDATA_I(dm_rdata), .DMEM_WE_O(dm_we), .DMEM_WDATA_O(dm_wdata), .PADDR_I(paddr),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  rps_mem_model u_mem (.clk_i(clk), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
    .dm_addr_i(dm_addr), .dm_re_i(dm_re), .dm_rdata_o(dm_rdata), .dm_we_i(dm_we),
    .dm_wdata_i(dm_wdata));
  // log fetch steps and data writes
  always @(posedge clk) begin
    // ignore the unknown address before reset takes hold
    if (rst_n && pm_addr !== last_a) fq.push_back(pm_addr);
    if (rst_n) last_a = pm_addr;
    if (dm_we === 1'b1) wq.push_back({dm_addr, dm_wdata});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // program run: fetch order, flush, alu flags, bank select
  task automatic t_program();
    logic [12:0] e;
    repeat (200) @(posedge clk);
    for (int i = 0; i < 18; i++) begin
      e = (i < 4) ? 13'(i) : ((i < 17) ? 13'(i + 12) : 13'h01F0);
      chk(32'(fq[i]), 32'(e));
    end
    for (int i = 0; i < 5; i++) chk(32'(wq[i]), 32'(wexp[i]));
    chk(32'(wq.size()), 32'h0000_0005);
  endtask : t_program
  // registers, unmapped place, core state, cycle clock
  task automatic t_apb();
    logic [31:0] rd;
    logic err, p;
    int n;
    apb(1'b1, rps_pkg::OFF_CTRL, 32'h0000_0001, rd, err);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF, rd, err);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, rps_pkg::OFF_CTRL, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0001);
    apb(1'b0, rps_pkg::OFF_CORE, 32'h0000_0000, rd, err);
    chk(rd & 32'h0000_FFFF, 32'h0000_383C);
    n = 0;
    p = cyc_clk;
    repeat (40) begin
      @(posedge clk);
      if (cyc_clk === 1'b1 && p === 1'b0) n++;
      p = cyc_clk;
    end
    chk(32'(n), 32'h0000_000A);
  endtask : t_apb
  // interrupt request lands on the vector
  task automatic t_irq();
    logic [31:0] rd;
    logic err;
    int n;
    apb(1'b1, rps_pkg::OFF_CTRL, 32'h0000_0005, rd, err);
    n = 0;
    while (pm_addr !== rps_pkg::INT_VEC && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(32'(pm_addr), 32'(rps_pkg::INT_VEC));
  endtask : t_irq
  // master clear restarts the program
  task automatic t_master_clear_pin();
    @(posedge clk);
    master_clear_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(pm_addr), 32'h0000_0000);
    wq.delete();
    master_clear_pin_n <= 1'b1;
    repeat (60) @(posedge clk);
    chk(32'(wq[0]), 32'(wexp[0]));
  endtask : t_master_clear_pin
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // main sequence: load program, reset, scenarios
  initial begin
    for (int i = 0; i < 2048; i++) u_mem.rom[i] = 14'h0000;
    u_mem.rom[0] = 14'h305A;
    u_mem.rom[1] = 14'h00A0;
    u_mem.rom[2] = 14'h2810;
    u_mem.rom[3] = 14'h00A1;
    u_mem.rom[4] = 14'h2804;
    u_mem.rom[16] = 14'h3EA6;
    u_mem.rom[17] = 14'h0803;
    u_mem.rom[18] = 14'h00A2;
    u_mem.rom[19] = 14'h3001;
    u_mem.rom[20] = 14'h3C00;
    u_mem.rom[21] = 14'h00A3;
    u_mem.rom[22] = 14'h0803;
    u_mem.rom[23] = 14'h00A4;
    u_mem.rom[24] = 14'h0830;
    u_mem.rom[25] = 14'h1683;
    u_mem.rom[26] = 14'h00A0;
    u_mem.rom[27] = 14'h2FF0;
    u_mem.rom[497] = 14'h29F0;
    u_mem.ram[48] = 8'h3C;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    master_clear_pin_n <= 1'b1;
    t_program();
    t_apb();
    t_irq();
    t_master_clear_pin();
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    #10000;
    miscompares++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
